// file: pkg/aes_cfg.svh
// Purpose: constants for the axis enable and start sequencer
// Assumes: 20 MHz module clock
// Notes:   offsets, fields, reset values and timing counts
`ifndef AES_CFG_SVH
`define AES_CFG_SVH

// ==========================================================================
// register offsets
`define AES_OFS_CTRL      4'h0
`define AES_OFS_SPEED     4'h1
`define AES_OFS_DEMAND    4'h2
`define AES_OFS_DECEL     4'h3
`define AES_OFS_STATUS    4'h4
`define AES_OFS_IRQ_STAT  4'h5
`define AES_OFS_IRQ_MASK  4'h6
`define AES_OFS_POSITION  4'h7
`define AES_OFS_TARGET    4'h8

// ==========================================================================
// control register fields
`define AES_CTRL_ENABLE   0
`define AES_CTRL_START    1
`define AES_CTRL_JOG_P    2
`define AES_CTRL_JOG_M    3
`define AES_CTRL_ERR_MON  4
`define AES_CTRL_SYNC_MON 5
`define AES_CTRL_REMOTE   6
`define AES_CTRL_W        7

// ==========================================================================
// interrupt status fields
`define AES_IRQ_READY_LOST 0
`define AES_IRQ_SENSOR_ERR 1
`define AES_IRQ_SYNC_ERR   2
`define AES_IRQ_MOVE_DONE  3
`define AES_IRQ_W          4

// ==========================================================================
// reset values and timing
`define AES_CTRL_RST      7'h10
`define AES_DECEL_RST     32'h0000_0100
`define AES_CLK_HZ        20000000
`define AES_SSI_HALF_NS   500
`define AES_SSI_HALF_CYC  ((`AES_SSI_HALF_NS * (`AES_CLK_HZ / 1000000)) / 1000)
`define AES_SSI_GAP_NS    30000
`define AES_SSI_GAP_CYC   ((`AES_SSI_GAP_NS * (`AES_CLK_HZ / 1000000)) / 1000)

`endif

// file: pkg/aes_pkg.sv
// Purpose: types for the axis enable and start sequencer
// Assumes: nothing
// Notes:   one-hot state codes
package aes_pkg;

  // ========================================================================
  // axis motion states
  typedef enum logic [3:0] {
    AES_IDLE = 4'h1,
    AES_HOLD = 4'h2,
    AES_JOG  = 4'h4,
    AES_MOVE = 4'h8
  } aes_axis_e;

  // ========================================================================
  // serial sensor reader states
  typedef enum logic [2:0] {
    AES_SSI_GAP   = 3'h1,
    AES_SSI_LOW   = 3'h2,
    AES_SSI_HIGH  = 3'h4
  } aes_ssi_e;

endpackage : aes_pkg

// file: logic/aes_ssi_reader.sv
// Purpose: serial position sensor reader, clock out and data in
// Assumes: both lines of the data pair arrive as separate levels, p is data, equal lines flag error
// Notes:   frame of WIDTH bits, msb first, pause between frames
`timescale 1ns/1ps
`include "aes_cfg.svh"

module aes_ssi_reader #(
  parameter int WIDTH = 24
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  output logic                  ssi_clk_p,
  output logic                  ssi_clk_n,
  input  wire logic             ssi_data_p,
  input  wire logic             ssi_data_n,
  output logic [WIDTH-1:0]      position,
  output logic                  position_valid,
  output logic                  sensor_error
);

  localparam int HALF = (`AES_SSI_HALF_CYC < 1) ? 1 : `AES_SSI_HALF_CYC;
  localparam int GAP  = (`AES_SSI_GAP_CYC < 1) ? 1 : `AES_SSI_GAP_CYC;

  aes_pkg::aes_ssi_e   state_reg,  state_next;
  logic [15:0]         cnt_reg,    cnt_next;
  logic [7:0]          bit_reg,    bit_next;
  logic [WIDTH-1:0]    shift_reg,  shift_next;
  logic [WIDTH-1:0]    pos_reg,    pos_next;
  logic                valid_reg,  valid_next;
  logic                err_reg,    err_next;
  logic                clk_reg,    clk_next;
  logic [1:0]          dp_sync_reg;
  logic [1:0]          dn_sync_reg;

  // ==========================================================================
  // pin synchronisers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dp_sync_reg <= 2'h0;
      dn_sync_reg <= 2'h3;
    end else begin
      dp_sync_reg <= {dp_sync_reg[0], ssi_data_p};
      dn_sync_reg <= {dn_sync_reg[0], ssi_data_n};
    end
  end

  // ==========================================================================
  // frame sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    pos_next   = pos_reg;
    valid_next = valid_reg;
    err_next   = err_reg;
    clk_next   = clk_reg;
    if (dp_sync_reg[1] == dn_sync_reg[1]) begin
      err_next = 1'b1;
    end
    case (state_reg)
      aes_pkg::AES_SSI_GAP: begin
        clk_next = 1'b1;
        if (cnt_reg >= 16'(GAP - 1)) begin
          cnt_next   = 16'h0000;
          bit_next   = 8'(WIDTH);
          err_next   = 1'b0;
          state_next = aes_pkg::AES_SSI_LOW;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      aes_pkg::AES_SSI_LOW: begin
        clk_next = 1'b0;
        if (cnt_reg >= 16'(HALF - 1)) begin
          cnt_next   = 16'h0000;
          state_next = aes_pkg::AES_SSI_HIGH;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      aes_pkg::AES_SSI_HIGH: begin
        clk_next = 1'b1;
        if (cnt_reg >= 16'(HALF - 1)) begin
          cnt_next   = 16'h0000;
          shift_next = {shift_reg[WIDTH-2:0], dp_sync_reg[1]};
          bit_next   = bit_reg - 8'h01;
          if (bit_reg == 8'h01) begin
            pos_next   = {shift_reg[WIDTH-2:0], dp_sync_reg[1]};
            valid_next = ~err_reg;
            state_next = aes_pkg::AES_SSI_GAP;
          end else begin
            state_next = aes_pkg::AES_SSI_LOW;
          end
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      default: begin
        state_next = aes_pkg::AES_SSI_GAP;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= aes_pkg::AES_SSI_GAP;
      cnt_reg   <= 16'h0000;
      bit_reg   <= 8'h00;
      shift_reg <= '0;
      pos_reg   <= '0;
      valid_reg <= 1'b0;
      err_reg   <= 1'b0;
      clk_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      pos_reg   <= pos_next;
      valid_reg <= valid_next;
      err_reg   <= err_next;
      clk_reg   <= clk_next;
    end
  end

  assign ssi_clk_p      = clk_reg;
  assign ssi_clk_n      = ~clk_reg;
  assign position       = pos_reg;
  assign position_valid = valid_reg;
  assign sensor_error   = ~valid_reg;

endmodule : aes_ssi_reader

// file: logic/aes_sequencer.sv
// Purpose: enable, ready, jog and start sequencing of a hydraulic axis
// Assumes: fieldbus bridge writes registers over the plain port
// Notes:   position units are sensor counts; speed is counts per tick
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "aes_cfg.svh"

module aes_sequencer #(
  parameter int POS_W = 24
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output logic [31:0]           reg_rdata,
  input  wire logic             hw_enable,
  input  wire logic             sync_start_in,
  output logic                  sync_start_out,
  output logic                  ready,
  input  wire logic             internal_error,
  input  wire logic             sync_fault,
  input  wire logic             remote_active,
  input  wire logic             remote_enable,
  input  wire logic             remote_start,
  input  wire logic             remote_jog_plus,
  input  wire logic             remote_jog_minus,
  output logic                  ssi_clk_p,
  output logic                  ssi_clk_n,
  input  wire logic             ssi_data_p,
  input  wire logic             ssi_data_n,
  output logic                  outputs_active,
  output logic                  loop_closed,
  output logic [POS_W-1:0]      setpoint,
  output logic                  in_position_window,
  output logic                  irq
);

  logic [`AES_CTRL_W-1:0]   ctrl_reg,    ctrl_next;
  logic [15:0]              speed_reg,   speed_next;
  logic [POS_W-1:0]         demand_reg,  demand_next;
  logic [POS_W-1:0]         decel_reg,   decel_next;
  logic [`AES_IRQ_W-1:0]    istat_reg,   istat_next;
  logic [`AES_IRQ_W-1:0]    imask_reg,   imask_next;
  logic [31:0]              rdata_reg,   rdata_next;
  aes_pkg::aes_axis_e       axis_reg,    axis_next;
  logic [POS_W-1:0]         sp_reg,      sp_next;
  logic [POS_W-1:0]         target_reg,  target_next;
  logic                     ready_reg,   ready_next;
  logic                     start_d_reg, start_d_next;
  logic [1:0]               hw_en_sync_reg;
  logic [1:0]               sync_in_reg;
  logic [POS_W-1:0]         position;
  logic                     pos_valid;
  logic                     sensor_err;
  logic                     enabled;
  logic                     start_eff;
  logic                     start_rise;
  logic                     jog_p;
  logic                     jog_m;
  logic                     fault;
  logic [`AES_IRQ_W-1:0]    events;

  // ==========================================================================
  // serial position sensor
  // sensor reader instance
  aes_ssi_reader #(
    .WIDTH          (POS_W)
  ) u_ssi (
    .clock          (clock),
    .arst_n         (arst_n),
    .ssi_clk_p      (ssi_clk_p),
    .ssi_clk_n      (ssi_clk_n),
    .ssi_data_p     (ssi_data_p),
    .ssi_data_n     (ssi_data_n),
    .position       (position),
    .position_valid (pos_valid),
    .sensor_error   (sensor_err)
  );

  // ==========================================================================
  // pin synchronisers
  // two-stage input sync
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hw_en_sync_reg <= 2'h0;
      sync_in_reg    <= 2'h0;
    end else begin
      hw_en_sync_reg <= {hw_en_sync_reg[0], hw_enable};
      sync_in_reg    <= {sync_in_reg[0], sync_start_in};
    end
  end

  // ==========================================================================
  // command selection
  always_comb begin
    if (ctrl_reg[`AES_CTRL_REMOTE] || remote_active) begin
      enabled   = remote_enable;
      start_eff = remote_start;
      jog_p     = remote_jog_plus;
      jog_m     = remote_jog_minus;
    end else begin
      enabled   = hw_en_sync_reg[1] & ctrl_reg[`AES_CTRL_ENABLE];
      start_eff = sync_in_reg[1];
      jog_p     = ctrl_reg[`AES_CTRL_JOG_P];
      jog_m     = ctrl_reg[`AES_CTRL_JOG_M];
    end
  end

  assign start_rise = start_eff & ~start_d_reg;

  assign fault = (ctrl_reg[`AES_CTRL_ERR_MON] & (sensor_err | internal_error))
               | (ctrl_reg[`AES_CTRL_SYNC_MON] & sync_fault);

  // ==========================================================================
  // axis motion
  always_comb begin
    axis_next    = axis_reg;
    sp_next      = sp_reg;
    target_next  = target_reg;
    start_d_next = start_eff;
    ready_next   = enabled & ~fault;
    case (axis_reg)
      aes_pkg::AES_IDLE: begin
        if (enabled) begin
          sp_next   = position;
          axis_next = aes_pkg::AES_HOLD;
        end
      end
      aes_pkg::AES_HOLD: begin
        if (start_rise && pos_valid) begin
          target_next = demand_reg;
          axis_next   = aes_pkg::AES_MOVE;
        end else if (!start_eff && (jog_p ^ jog_m)) begin
          axis_next = aes_pkg::AES_JOG;
        end
      end
      aes_pkg::AES_JOG: begin
        if (start_eff || !(jog_p ^ jog_m)) begin
          axis_next = aes_pkg::AES_HOLD;
        end else if (jog_p) begin
          sp_next = sp_reg + POS_W'(speed_reg);
        end else begin
          sp_next = sp_reg - POS_W'(speed_reg);
        end
      end
      aes_pkg::AES_MOVE: begin
        if (!start_eff) begin
          if (target_reg > sp_reg && target_reg - sp_reg > decel_reg) begin
            target_next = sp_reg + decel_reg;
          end else if (sp_reg > target_reg && sp_reg - target_reg > decel_reg)
          begin
            target_next = sp_reg - decel_reg;
          end
        end
        if (sp_reg == target_reg) begin
          axis_next = aes_pkg::AES_HOLD;
        end else if (target_reg > sp_reg) begin
          sp_next = (target_reg - sp_reg > POS_W'(speed_reg))
                  ? sp_reg + POS_W'(speed_reg) : target_reg;
        end else begin
          sp_next = (sp_reg - target_reg > POS_W'(speed_reg))
                  ? sp_reg - POS_W'(speed_reg) : target_reg;
        end
      end
      default: begin
        axis_next = aes_pkg::AES_IDLE;
      end
    endcase
    if (!enabled) begin
      axis_next  = aes_pkg::AES_IDLE;
      ready_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      axis_reg    <= aes_pkg::AES_IDLE;
      sp_reg      <= '0;
      target_reg  <= '0;
      start_d_reg <= 1'b0;
      ready_reg   <= 1'b0;
    end else begin
      axis_reg    <= axis_next;
      sp_reg      <= sp_next;
      target_reg  <= target_next;
      start_d_reg <= start_d_next;
      ready_reg   <= ready_next;
    end
  end

  // ==========================================================================
  // register port and interrupts
  assign events = {
    (axis_reg == aes_pkg::AES_MOVE) && (axis_next == aes_pkg::AES_HOLD),
    ctrl_reg[`AES_CTRL_SYNC_MON] & sync_fault,
    enabled & sensor_err,
    ready_reg & ~ready_next
  };

  always_comb begin
    ctrl_next   = ctrl_reg;
    speed_next  = speed_reg;
    demand_next = demand_reg;
    decel_next  = decel_reg;
    imask_next  = imask_reg;
    istat_next  = istat_reg;
    rdata_next  = 32'h0000_0000;
    if (reg_write) begin
      case (reg_addr)
        `AES_OFS_CTRL:     ctrl_next   = reg_wdata[`AES_CTRL_W-1:0];
        `AES_OFS_SPEED:    speed_next  = reg_wdata[15:0];
        `AES_OFS_DEMAND:   demand_next = reg_wdata[POS_W-1:0];
        `AES_OFS_DECEL:    decel_next  = reg_wdata[POS_W-1:0];
        `AES_OFS_IRQ_STAT: istat_next  = istat_reg & ~reg_wdata[`AES_IRQ_W-1:0];
        `AES_OFS_IRQ_MASK: imask_next  = reg_wdata[`AES_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // set wins over clear
    istat_next = istat_next | events;
    if (reg_read) begin
      case (reg_addr)
        `AES_OFS_CTRL:     rdata_next = 32'(ctrl_reg);
        `AES_OFS_SPEED:    rdata_next = 32'(speed_reg);
        `AES_OFS_DEMAND:   rdata_next = 32'(demand_reg);
        `AES_OFS_DECEL:    rdata_next = 32'(decel_reg);
        `AES_OFS_STATUS:   rdata_next = {24'h000000, axis_reg, pos_valid,
                                         in_position_window, enabled,
                                         ready_reg};
        `AES_OFS_IRQ_STAT: rdata_next = 32'(istat_reg);
        `AES_OFS_IRQ_MASK: rdata_next = 32'(imask_reg);
        `AES_OFS_POSITION: rdata_next = 32'(position);
        `AES_OFS_TARGET:   rdata_next = 32'(target_reg);
        default:           rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg   <= `AES_CTRL_RST;
      speed_reg  <= 16'h0000;
      demand_reg <= '0;
      decel_reg  <= POS_W'(`AES_DECEL_RST);
      istat_reg  <= '0;
      imask_reg  <= '0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      speed_reg  <= speed_next;
      demand_reg <= demand_next;
      decel_reg  <= decel_next;
      istat_reg  <= istat_next;
      imask_reg  <= imask_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ==========================================================================
  // outputs
  // bus start relayed
  assign sync_start_out     = ctrl_reg[`AES_CTRL_START] & ~remote_active
                            & ~ctrl_reg[`AES_CTRL_REMOTE];
  assign ready              = ready_reg;
  assign outputs_active     = axis_reg != aes_pkg::AES_IDLE;
  assign loop_closed        = axis_reg != aes_pkg::AES_IDLE;
  assign setpoint           = sp_reg;
  assign in_position_window = (axis_reg == aes_pkg::AES_HOLD) & pos_valid
                            & (position == sp_reg);
  assign irq                = |(istat_reg & imask_reg);
  assign reg_rdata          = rdata_reg;

endmodule : aes_sequencer

// file: verif/aes_seq_assertions.sv
// Purpose: port checks for the axis sequencer
// Assumes: ctrl, speed and mask are shadowed from bus writes
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`include "aes_cfg.svh"

module aes_seq_assertions #(
  parameter int POS_W = 24
) (
  input wire logic             clock,
  input wire logic             arst_n,
  input wire logic [3:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_write,
  input wire logic             reg_read,
  input wire logic [31:0]      reg_rdata,
  input wire logic             hw_enable,
  input wire logic             remote_active,
  input wire logic             remote_enable,
  input wire logic             internal_error,
  input wire logic             sync_fault,
  input wire logic             sync_start_out,
  input wire logic             ready,
  input wire logic             outputs_active,
  input wire logic [POS_W-1:0] setpoint,
  input wire logic             irq,
  input wire logic             ssi_clk_p,
  input wire logic             ssi_clk_n
);
  // ==========
  // shadows of bus-written control state
  logic [6:0] ctl_reg;
  logic       spd_zero_reg;
  logic       msk_zero_reg;
  logic       remote_mode;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg      <= `AES_CTRL_RST;
      spd_zero_reg <= 1'b1;
      msk_zero_reg <= 1'b1;
    end else if (reg_write) begin
      if (reg_addr == `AES_OFS_CTRL)
        ctl_reg <= reg_wdata[6:0];
      if (reg_addr == `AES_OFS_SPEED)
        spd_zero_reg <= (reg_wdata[15:0] == 16'h0);
      if (reg_addr == `AES_OFS_IRQ_MASK)
        msk_zero_reg <= (reg_wdata[3:0] == 4'h0);
    end
  end
  assign remote_mode = remote_active | ctl_reg[`AES_CTRL_REMOTE];

  // ==========
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  no_en_ready_a:
    assert property ((!hw_enable && !remote_enable)[*4] |-> !ready)
    else $error("ready high while disabled");
  no_en_out_a:
    assert property ((!hw_enable && !remote_enable)[*4] |-> !outputs_active)
    else $error("outputs active while disabled");
  int_err_ready_a:
    assert property (internal_error && ctl_reg[`AES_CTRL_ERR_MON] |=> !ready)
    else $error("ready kept through monitored error");
  sync_ready_a:
    assert property (sync_fault && ctl_reg[`AES_CTRL_SYNC_MON] |=> !ready)
    else $error("ready kept through sync fault");
  start_copy_a:
    assert property (!remote_mode |->
      sync_start_out == ctl_reg[`AES_CTRL_START])
    else $error("sync start output differs from bus start");
  remote_start_a:
    assert property (remote_mode |-> !sync_start_out)
    else $error("bus start relayed in remote mode");
  zero_speed_a:
    assert property (outputs_active && spd_zero_reg |=>
      $stable(setpoint) || !outputs_active)
    else $error("setpoint moved at zero speed");
  rdata_idle_a:
    assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  irq_mask_a:
    assert property (msk_zero_reg [*2] |-> !irq)
    else $error("interrupt with all sources masked");
  clk_pair_a:
    assert property (ssi_clk_n == !ssi_clk_p)
    else $error("sensor clock pair not complementary");
  clk_low_a:
    assert property ($fell(ssi_clk_p) |=>
      !ssi_clk_p [*8] ##1 !ssi_clk_p ##1 ssi_clk_p)
    else $error("sensor clock low phase not ten cycles");
endmodule : aes_seq_assertions

// file: verif/aes_ssi_sensor.sv
// Purpose: serial absolute position sensor model
// Assumes: a frame starts after a long clock-high pause
// Notes:   fault makes both data lines equal
`timescale 1ns/1ps

module aes_ssi_sensor #(
  parameter int WIDTH = 24
) (
  input  wire logic             clock,
  input  wire logic             ssi_clk_p,
  input  wire logic [WIDTH-1:0] pos,
  input  wire logic             fault,
  output logic                  ssi_data_p,
  output logic                  ssi_data_n
);
  logic [WIDTH-1:0] shift_reg = '0;
  logic             line      = 1'b1;
  int               idle_cnt  = 0;

  always @(posedge clock) idle_cnt <= ssi_clk_p ? idle_cnt + 1 : 0;
  always @(negedge ssi_clk_p) if (idle_cnt > 50) shift_reg <= pos;
  always @(posedge ssi_clk_p) begin
    line      <= shift_reg[WIDTH-1];
    shift_reg <= {shift_reg[WIDTH-2:0], 1'b1};
  end
  // line returns to idle high once the frame times out
  assign ssi_data_p = (idle_cnt > 40) ? 1'b1 : line;
  assign ssi_data_n = fault ? ssi_data_p : ~ssi_data_p;
endmodule : aes_ssi_sensor

// file: verif/axis_enable_start_sequencer_tb.sv
// Purpose: self-checking bench for the axis sequencer
// Assumes: 20 MHz clock, sensor model on the serial pins
// Notes:   start output looped to the sync input, as on a master axis
`timescale 1ns/1ps
`include "aes_cfg.svh"

module axis_enable_start_sequencer_tb;
  localparam logic [23:0] POS0 = 24'h00_1234;
  logic        clock = 1'b0, arst_n = 1'b0, reg_write = 1'b0;
  logic        reg_read = 1'b0, hw_enable = 1'b0, sync_start_in = 1'b0;
  logic        internal_error = 1'b0, sync_fault = 1'b0, error_monitor_select_fault = 1'b0;
  logic        remote_active = 1'b0, remote_enable = 1'b0, remote_jog = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [23:0] setpoint;
  logic        sync_start_out, ready, outputs_active, loop_closed, irq;
  logic        in_position_window, ssi_clk_p, ssi_clk_n;
  logic        ssi_data_p, ssi_data_n;
  int          n_errors = 0, compares = 0;

  // ==========
  // design, sensor and start loop
  aes_sequencer #(.POS_W(24)) u_aes_sequencer (
    .clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .hw_enable, .sync_start_in, .sync_start_out, .ready,
    .internal_error, .sync_fault, .remote_active, .remote_enable,
    .remote_start(1'b0), .remote_jog_plus(remote_jog),
    .remote_jog_minus(1'b0),
    .ssi_clk_p, .ssi_clk_n, .ssi_data_p, .ssi_data_n, .outputs_active,
    .loop_closed, .setpoint, .in_position_window, .irq);
  aes_ssi_sensor #(.WIDTH(24)) u_aes_ssi_sensor (.clock, .ssi_clk_p,
    .pos(POS0), .fault(error_monitor_select_fault), .ssi_data_p, .ssi_data_n);
  always @(posedge clock) sync_start_in <= sync_start_out;
  initial forever #25 clock = ~clock;

  // ==========
  // bus, compare and closing tasks
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic jog_step(input logic [31:0] ctl, input logic [23:0] delta,
                          input string what);
    logic [23:0] s;
    logic [23:0] e;
    wr(`AES_OFS_CTRL, ctl);
    wait_cyc(5);
    s = setpoint;
    e = s + delta;
    wait_cyc(10);
    chk(what, 32'(e), 32'(setpoint));
  endtask : jog_step

  // ==========
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    rd(`AES_OFS_CTRL, d);
    chk("ctrl reset", 32'(`AES_CTRL_RST), d);
    rd(`AES_OFS_DECEL, d);
    chk("decel reset", `AES_DECEL_RST, d);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, d);
    chk("unmapped", 32'h0, d);
    chk("sensor clock idle", 32'h2, 32'({ssi_clk_p, ssi_clk_n}));
  endtask : t_reset
  task automatic t_enable;
    @(posedge clock);
    hw_enable <= 1'b1;
    wait_cyc(8);
    chk("hw only", 32'h0, 32'({outputs_active, ready}));
    wr(`AES_OFS_CTRL, 32'h11);
    wait_cyc(6);
    chk("enabled", 32'h3, 32'({outputs_active, loop_closed}));
    chk("ready on", 32'h1, 32'(ready));
    chk("hold here", 32'(POS0), 32'(setpoint));
    chk("in window", 32'h1, 32'(in_position_window));
  endtask : t_enable
  task automatic t_jog;
    jog_step(32'h15, 24'd0, "zero speed");
    wr(`AES_OFS_SPEED, 32'h3);
    jog_step(32'h15, 24'd30, "jog plus");
    jog_step(32'h19, -24'd30, "jog minus");
    jog_step(32'h11, 24'd0, "jog release");
  endtask : t_jog
  task automatic t_sensor;
    @(posedge clock);
    error_monitor_select_fault <= 1'b1;
    wait_cyc(2500);
    chk("sensor ready", 32'h0, 32'(ready));
    jog_step(32'h15, 24'd30, "blind jog");
    wr(`AES_OFS_CTRL, 32'h11);
    wr(`AES_OFS_IRQ_MASK, 32'h2);
    wait_cyc(2);
    chk("irq raised", 32'h1, 32'(irq));
    wr(`AES_OFS_IRQ_MASK, 32'h0);
    wait_cyc(2);
    chk("irq masked", 32'h0, 32'(irq));
    @(posedge clock);
    error_monitor_select_fault <= 1'b0;
    wait_cyc(2500);
    wr(`AES_OFS_IRQ_STAT, 32'hF);
    wr(`AES_OFS_IRQ_MASK, 32'h2);
    wait_cyc(2);
    chk("irq cleared", 32'h0, 32'(irq));
    chk("ready back", 32'h1, 32'(ready));
  endtask : t_sensor
  task automatic t_faults;
    @(posedge clock);
    internal_error <= 1'b1;
    wait_cyc(3);
    chk("int error", 32'h0, 32'(ready));
    wr(`AES_OFS_CTRL, 32'h01);
    wait_cyc(3);
    chk("unmonitored", 32'h1, 32'(ready));
    @(posedge clock);
    internal_error <= 1'b0;
    sync_fault     <= 1'b1;
    wait_cyc(3);
    chk("sync off", 32'h1, 32'(ready));
    wr(`AES_OFS_CTRL, 32'h21);
    wait_cyc(3);
    chk("sync on", 32'h0, 32'(ready));
    @(posedge clock);
    sync_fault <= 1'b0;
    wr(`AES_OFS_CTRL, 32'h11);
  endtask : t_faults
  task automatic t_start;
    logic [31:0] d;
    logic [23:0] s;
    int          i;
    wr(`AES_OFS_DEMAND, 32'(POS0 + 24'd60));
    wr(`AES_OFS_CTRL, 32'h13);
    wait_cyc(1);
    chk("sync out", 32'h1, 32'(sync_start_out));
    for (i = 0; i < 200 && setpoint !== POS0 + 24'd60; i++) wait_cyc(1);
    chk("target hit", 32'(POS0 + 24'd60), 32'(setpoint));
    if (i == 200) tally_and_finish();
    rd(`AES_OFS_TARGET, d);
    chk("target latch", 32'(POS0 + 24'd60), d);
    wr(`AES_OFS_CTRL, 32'h11);
    wr(`AES_OFS_DECEL, 32'd30);
    wr(`AES_OFS_DEMAND, 32'(POS0 + 24'd3000));
    wr(`AES_OFS_CTRL, 32'h13);
    wait_cyc(20);
    wr(`AES_OFS_CTRL, 32'h11);
    wait_cyc(0);
    s = setpoint;
    wait_cyc(100);
    chk("decel stop", 32'h1, 32'((setpoint - s) <= 24'd48));
  endtask : t_start
  task automatic t_remote;
    @(posedge clock);
    remote_active <= 1'b1;
    remote_enable <= 1'b1;
    hw_enable     <= 1'b0;
    wr(`AES_OFS_CTRL, 32'h12);
    wait_cyc(6);
    chk("remote on", 32'h1, 32'(outputs_active));
    chk("remote relay", 32'h0, 32'(sync_start_out));
    @(posedge clock);
    remote_jog <= 1'b1;
    jog_step(32'h12, 24'd30, "remote jog");
    @(posedge clock);
    remote_enable <= 1'b0;
    remote_jog    <= 1'b0;
    wait_cyc(6);
    chk("remote off", 32'h0, 32'({outputs_active, ready}));
    @(posedge clock);
    remote_active <= 1'b0;
    wr(`AES_OFS_CTRL, 32'h42);
    wait_cyc(2);
    chk("remote bit", 32'h0, 32'({outputs_active, sync_start_out}));
  endtask : t_remote

  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    wait_cyc(2);
    t_reset();
    wait_cyc(2500);
    t_enable();
    t_jog();
    t_sensor();
    t_faults();
    t_start();
    t_remote();
    tally_and_finish();
  end
endmodule : axis_enable_start_sequencer_tb

bind aes_sequencer aes_seq_assertions #(.POS_W(POS_W)) u_aes_seq_assertions (
  .clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .hw_enable, .remote_active, .remote_enable, .internal_error, .sync_fault,
  .sync_start_out, .ready, .outputs_active, .setpoint, .irq, .ssi_clk_p,
  .ssi_clk_n);
